// ===== sws_sched_mem.sv
`timescale 1ns/1ps
`default_nettype none

package sws_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          SCHED_AW      = 5;
	localparam int          SCHED_DEPTH   = 32;
	localparam int          CNT_W         = 7;
	localparam int          SYNC_N        = 6;
	// Register byte addresses
	localparam logic [7:0]  ADR_CTRL      = 8'h00;
	localparam logic [7:0]  ADR_STATION   = 8'h04;
	localparam logic [7:0]  ADR_STATUS    = 8'h08;
	localparam logic [7:0]  ADR_IRQ_STAT  = 8'h0C;
	localparam logic [7:0]  ADR_IRQ_MASK  = 8'h10;
	localparam logic [7:0]  ADR_SCHED_SEL = 8'h14;
	localparam logic [7:0]  ADR_SCHED_DAT = 8'h18;
	// Field positions
	localparam int          CTRL_DIAL_LSB = 8;
	localparam int          CTRL_CHAIN    = 16;
	localparam int          SEL_PCT_LSB   = 8;
	localparam int          DAT_SQZ_LSB   = 0;
	localparam int          DAT_HEAT_LSB  = 7;
	localparam int          DAT_COOL_LSB  = 14;
	localparam int          DAT_HOLD_LSB  = 21;
	localparam int          STS_STATE_LSB = 8;
	localparam int          STS_SCHED_LSB = 16;
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_FAULT     = 1;
	localparam int          IRQ_SCHED     = 2;
	// Values
	localparam logic [7:0]  SEAM_SPOT     = 8'h00;
	localparam logic [7:0]  SEAM_ADJUST   = 8'h02;
	localparam logic [7:0]  SEAM_COMBO    = 8'h03;
	localparam logic [3:0]  SEAM_DELAY_LO = 4'h4;
	localparam logic [4:0]  SCHED_SECOND  = 5'h0A;
	localparam logic [4:0]  SCHED_THIRD   = 5'h14;
	localparam logic [6:0]  PCT_MAX       = 7'h63;
	localparam logic [6:0]  CNT_ZERO      = 7'h00;
	localparam logic [6:0]  CNT_ONE       = 7'h01;
	localparam logic [7:0]  ERR_OVERTEMP  = 8'h01;
	localparam logic [7:0]  ERR_NONE      = 8'h00;
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [5:0]  STATION_RST   = 6'h00;
	localparam logic [2:0]  IRQ_RST       = 3'h0;
	localparam logic [5:0]  SYNC_RST      = 6'h10;

	typedef enum logic [2:0] {
		ST_IDLE, ST_PRE, ST_SQUEEZE, ST_HEAT, ST_COOL, ST_HOLD, ST_DONE
	} sws_state_type;

	typedef struct packed {
		logic [6:0] pct;
		logic [6:0] hold;
		logic [6:0] cool;
		logic [6:0] heat;
		logic [6:0] squeeze;
	} sws_sched_type;

	typedef struct packed {
		logic                initiate_third;
		logic                initiate_second;
		logic                initiate_dialed;
	} sws_init_type;
endpackage

module sws_sched_mem (
	input  wire logic                           clk_i,
	input  wire logic                           resetn_i,
	input  wire logic                           wr_en_i,
	input  wire logic [sws_pkg::SCHED_AW-1:0]   wr_addr_i,
	input  wire sws_pkg::sws_sched_type         wr_data_i,
	input  wire logic [sws_pkg::SCHED_AW-1:0]   rd_addr_i,
	output var  sws_pkg::sws_sched_type         rd_data_o
);
	import sws_pkg::*;

	sws_sched_type mem_q [SCHED_DEPTH];

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end
endmodule // sws_sched_mem

`default_nettype wire

// ===== sws_seam_seq.sv
// Notes on behaviour
// - Seam setting zero runs plain spot sequences
// - Current switches on line cycle boundaries, except an open temperature switch cuts it at once
// - Intermittent: current in heat, none in cool
// - Heat lasts at least one line cycle
// - Opening during heat goes straight to hold
// - Opening during cool finishes cool, then hold
// - Zero cool count gives continuous current
// - Highest closed input picks schedule dial/10/20
// - Schedule changes apply mid interval at once
// - Open temperature switch shows error, faults
// - Sub-mode two: buttons raise, lower percent
// - Sub-mode three: second input runs spot
// - Sub-mode three: optional currentless spot first
// - x4 setting: measure first x cycles only
// - Station number addresses one of 64 controls
// - All counts are mains line cycles
// - No schedule chaining in normal seam
`timescale 1ns/1ps
`default_nettype none

module sws_seam_seq (
	input  wire logic                        clk_i,
	input  wire logic                        resetn_i,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [sws_pkg::ADDR_W-1:0]  paddr_i,
	input  wire logic [sws_pkg::DATA_W-1:0]  pwdata_i,
	output var  logic [sws_pkg::DATA_W-1:0]  prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o,
	input  wire sws_pkg::sws_init_type       init_i,
	input  wire logic                        line_sync_i,
	input  wire logic                        temp_switch_closed_i,
	input  wire logic                        data_tens_btn_i,
	input  wire logic                        data_units_btn_i,
	output var  logic                        weld_fire_o,
	output var  logic [6:0]                  percent_o,
	output var  logic                        measure_only_o,
	output var  logic                        regulate_o,
	output var  logic [7:0]                  error_code_o,
	output var  logic                        fault_o,
	output var  logic [5:0]                  station_id_o,
	output logic                             irq_o
);
	import sws_pkg::*;

	logic [SYNC_N-1:0]    s1_q, s2_q, prev_q;
	logic [31:0]          ctrl_q;
	logic [5:0]           station_q;
	logic [2:0]           irq_stat_q, irq_mask_q;
	logic [4:0]           sel_idx_q;
	logic [6:0]           sel_pct_q;
	sws_state_type        state_q, state_d;
	logic [CNT_W-1:0]     cnt_q, cnt_d;
	logic [CNT_W-1:0]     cyc_q;
	logic                 spot_q, spot_d, dry_q, dry_d;
	logic [4:0]           act_q;
	logic                 reload_q;
	logic [6:0]           pct_q;
	sws_sched_type        rd_sched;

	// Synchronised pins: line, temp, buttons, initiations
	wire [SYNC_N-1:0] pins = {line_sync_i, temp_switch_closed_i, data_tens_btn_i,
		data_units_btn_i, init_i.initiate_second, init_i.initiate_third};
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			prev_q <= SYNC_RST;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			prev_q <= s2_q;
		end
	end
	logic dial_s1_q, dial_s2_q;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dial_s1_q <= 1'b0;
			dial_s2_q <= 1'b0;
		end else begin
			dial_s1_q <= init_i.initiate_dialed;
			dial_s2_q <= dial_s1_q;
		end
	end

	wire line_tick  = s2_q[5] & ~prev_q[5];
	wire temp_ok    = s2_q[4];
	wire up_edge    = s2_q[3] & ~prev_q[3];
	wire dn_edge    = s2_q[2] & ~prev_q[2];
	wire in_second  = s2_q[1];
	wire in_third   = s2_q[0];
	wire in_dialed  = dial_s2_q;
	wire any_init   = in_dialed | in_second | in_third;

	// Mode decode
	wire [7:0] seam_set  = ctrl_q[7:0];
	wire [4:0] dial      = ctrl_q[CTRL_DIAL_LSB +: 5];
	wire       chain_pre = ctrl_q[CTRL_CHAIN];
	wire       seam_on   = (seam_set != SEAM_SPOT);
	wire       sub_adj   = (seam_set == SEAM_ADJUST);
	wire       sub_combo = (seam_set == SEAM_COMBO);
	wire       delay_md  = (seam_set[3:0] == SEAM_DELAY_LO);
	wire [6:0] delay_x   = {3'h0, seam_set[7:4]};

	// Priority: highest closed input wins; combo spot pins schedule 10
	wire [4:0] act_sched = (sub_combo && spot_q) ? SCHED_SECOND :
		in_third ? SCHED_THIRD : in_second ? SCHED_SECOND : dial;

	wire [6:0] heat_lim = (rd_sched.heat == CNT_ZERO) ? CNT_ONE : rd_sched.heat;
	wire [6:0] cnt_inc  = cnt_q + CNT_ONE;
	wire       fire_d   = (state_d == ST_HEAT) && !dry_d;
	wire       jump_spot = sub_combo && in_second && !spot_q;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		spot_d  = spot_q;
		dry_d   = dry_q;
		if (!temp_ok) begin
			state_d = ST_IDLE;
			cnt_d   = CNT_ZERO;
			spot_d  = 1'b0;
			dry_d   = 1'b0;
		end else if (line_tick) begin
			cnt_d = cnt_inc;
			case (state_q)
				ST_IDLE: begin
					cnt_d = CNT_ZERO;
					if (any_init) begin
						spot_d = !seam_on || (sub_combo && in_second);
						if (sub_combo && chain_pre && in_dialed && !in_second) begin
							state_d = ST_PRE;
							dry_d   = 1'b1;
						end else begin
							state_d = ST_SQUEEZE;
						end
					end
				end
				ST_PRE: begin
					if (cnt_inc >= heat_lim) begin
						state_d = ST_SQUEEZE;
						cnt_d   = CNT_ZERO;
						dry_d   = 1'b0;
					end
				end
				ST_SQUEEZE: begin
					if (cnt_inc >= rd_sched.squeeze) begin
						state_d = ST_HEAT;
						cnt_d   = CNT_ZERO;
					end
				end
				ST_HEAT: begin
					if (spot_q) begin
						if (cnt_inc >= heat_lim) begin
							state_d = ST_HOLD;
							cnt_d   = CNT_ZERO;
						end
					end else if (!any_init) begin
						state_d = ST_HOLD;
						cnt_d   = CNT_ZERO;
					end else if (jump_spot) begin
						spot_d = 1'b1;
						cnt_d  = CNT_ZERO;
					end else if (cnt_inc >= heat_lim) begin
						cnt_d = CNT_ZERO;
						if (rd_sched.cool != CNT_ZERO) begin
							state_d = ST_COOL;
						end
					end
				end
				ST_COOL: begin
					if (jump_spot) begin
						state_d = ST_HEAT;
						spot_d  = 1'b1;
						cnt_d   = CNT_ZERO;
					end else if (cnt_inc >= rd_sched.cool) begin
						state_d = any_init ? ST_HEAT : ST_HOLD;
						cnt_d   = CNT_ZERO;
					end
				end
				ST_HOLD: begin
					if (cnt_inc >= rd_sched.hold) begin
						state_d = ST_DONE;
						cnt_d   = CNT_ZERO;
					end
				end
				ST_DONE: begin
					cnt_d = CNT_ZERO;
					spot_d = 1'b0;
					if (!any_init) begin
						state_d = ST_IDLE;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q     <= ST_IDLE;
			cnt_q       <= CNT_ZERO;
			spot_q      <= 1'b0;
			dry_q       <= 1'b0;
			weld_fire_o <= 1'b0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			spot_q      <= spot_d;
			dry_q       <= dry_d;
			weld_fire_o <= fire_d;
		end
	end

	// Weld cycle count for delayed regulation
	wire [6:0] cyc_d = (state_q == ST_IDLE) ? CNT_ZERO :
		(line_tick && fire_d && cyc_q != PCT_MAX) ? cyc_q + CNT_ONE : cyc_q;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cyc_q          <= CNT_ZERO;
			measure_only_o <= 1'b0;
			regulate_o     <= 1'b0;
		end else begin
			cyc_q          <= cyc_d;
			measure_only_o <= fire_d && delay_md && (cyc_d <= delay_x);
			regulate_o     <= fire_d && !(delay_md && (cyc_d <= delay_x));
		end
	end

	// Live percent: reload on schedule change, buttons adjust in sub-mode two
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			act_q    <= '0;
			reload_q <= 1'b1;
			pct_q    <= CNT_ZERO;
		end else begin
			act_q    <= act_sched;
			reload_q <= (act_sched != act_q) || (state_q == ST_IDLE);
			if (reload_q) begin
				pct_q <= rd_sched.pct;
			end else if (sub_adj && up_edge && pct_q < PCT_MAX) begin
				pct_q <= pct_q + CNT_ONE;
			end else if (sub_adj && dn_edge && pct_q != CNT_ZERO) begin
				pct_q <= pct_q - CNT_ONE;
			end
		end
	end
	assign percent_o = pct_q;

	// APB decode
	wire acc      = psel_i && penable_i;
	wire setup    = psel_i && !penable_i;
	wire hit_ctrl = (paddr_i == ADR_CTRL);
	wire hit_sta  = (paddr_i == ADR_STATION);
	wire hit_sts  = (paddr_i == ADR_STATUS);
	wire hit_irq  = (paddr_i == ADR_IRQ_STAT);
	wire hit_msk  = (paddr_i == ADR_IRQ_MASK);
	wire hit_sel  = (paddr_i == ADR_SCHED_SEL);
	wire hit_dat  = (paddr_i == ADR_SCHED_DAT);
	wire mapped   = hit_ctrl | hit_sta | hit_sts | hit_irq | hit_msk | hit_sel | hit_dat;
	wire wr       = acc && pwrite_i && mapped;
	wire wr_sched = wr && hit_dat;
	sws_sched_type wr_word;
	assign wr_word = {sel_pct_q, pwdata_i[DAT_HOLD_LSB +: 7], pwdata_i[DAT_COOL_LSB +: 7],
		pwdata_i[DAT_HEAT_LSB +: 7], pwdata_i[DAT_SQZ_LSB +: 7]};

	sws_sched_mem u_mem (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.wr_en_i   (wr_sched),
		.wr_addr_i (sel_idx_q),
		.wr_data_i (wr_word),
		.rd_addr_i (act_sched),
		.rd_data_o (rd_sched)
	);

	assign pready_o  = 1'b1;
	assign pslverr_o = acc && !mapped;

	logic [31:0] rdata;
	always_comb begin
		if (hit_ctrl) begin
			rdata = ctrl_q;
		end else if (hit_sta) begin
			rdata = {26'h0, station_q};
		end else if (hit_sts) begin
			rdata = {11'h0, act_q, 5'h0, state_q, 7'h0, fault_o};
		end else if (hit_irq) begin
			rdata = {29'h0, irq_stat_q};
		end else if (hit_msk) begin
			rdata = {29'h0, irq_mask_q};
		end else if (hit_sel) begin
			rdata = {17'h0, sel_pct_q, 3'h0, sel_idx_q};
		end else begin
			rdata = 32'h0000_0000;
		end
	end

	// Events; set beats a read clear
	wire [2:0] ev;
	assign ev[IRQ_DONE]  = (state_d == ST_DONE) && (state_q != ST_DONE);
	assign ev[IRQ_FAULT] = !temp_ok && !fault_o;
	assign ev[IRQ_SCHED] = reload_q && (state_q == ST_HEAT || state_q == ST_COOL);
	wire [2:0] irq_clr = (acc && !pwrite_i && hit_irq) ? prdata_o[2:0] : IRQ_RST;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q     <= CTRL_RST;
			station_q  <= STATION_RST;
			irq_mask_q <= IRQ_RST;
			irq_stat_q <= IRQ_RST;
			sel_idx_q  <= '0;
			sel_pct_q  <= CNT_ZERO;
			prdata_o   <= 32'h0000_0000;
		end else begin
			if (wr && hit_ctrl) ctrl_q <= pwdata_i;
			if (wr && hit_sta) station_q <= pwdata_i[5:0];
			if (wr && hit_msk) irq_mask_q <= pwdata_i[2:0];
			if (wr && hit_sel) begin
				sel_idx_q <= pwdata_i[4:0];
				sel_pct_q <= pwdata_i[SEL_PCT_LSB +: 7];
			end
			irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
			if (setup) prdata_o <= rdata;
		end
	end
	assign irq_o        = |(irq_stat_q & irq_mask_q);
	assign station_id_o = station_q;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fault_o      <= 1'b0;
			error_code_o <= ERR_NONE;
		end else begin
			fault_o      <= !temp_ok;
			error_code_o <= temp_ok ? ERR_NONE : ERR_OVERTEMP;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	property p_fire_heat;
		weld_fire_o |-> (state_q == ST_HEAT) && !dry_q;
	endproperty
	a_fire_heat: assert property (p_fire_heat) else $error("Fire outside heat");
	property p_fire_sync;
		$changed(weld_fire_o) && temp_ok && $past(temp_ok) |-> $past(line_tick);
	endproperty
	a_fire_sync: assert property (p_fire_sync) else $error("Fire changed off tick");
	property p_fault_off;
		!temp_ok |=> !weld_fire_o && (error_code_o == ERR_OVERTEMP);
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("Fault did not stop");
	property p_heat_open;
		temp_ok && line_tick && state_q == ST_HEAT && !spot_q && !any_init
			|=> state_q == ST_HOLD;
	endproperty
	a_heat_open: assert property (p_heat_open) else $error("Heat open no hold");
	property p_cool_keep;
		temp_ok && line_tick && state_q == ST_COOL && !jump_spot && cnt_inc < rd_sched.cool
			|=> state_q == ST_COOL;
	endproperty
	a_cool_keep: assert property (p_cool_keep) else $error("Cool cut short");
	property p_cont;
		temp_ok && line_tick && state_q == ST_HEAT && !spot_q && any_init && !jump_spot
			&& rd_sched.cool == CNT_ZERO |=> state_q == ST_HEAT;
	endproperty
	a_cont: assert property (p_cont) else $error("Continuous broke");
	property p_prio;
		in_third && !(sub_combo && spot_q) |-> ##1 act_q == SCHED_THIRD;
	endproperty
	a_prio: assert property (p_prio) else $error("Third not schedule 20");
	property p_pct;
		sub_adj && !reload_q && up_edge && pct_q < PCT_MAX |=> pct_q == $past(pct_q) + CNT_ONE;
	endproperty
	a_pct: assert property (p_pct) else $error("Percent not raised");
	property p_meas;
		measure_only_o |-> delay_md && cyc_q <= delay_x && !regulate_o;
	endproperty
	a_meas: assert property (p_meas) else $error("Measure past delay");
	property p_spot_nocool;
		!seam_on && state_q == ST_IDLE && line_tick && any_init && temp_ok
			|=> spot_q;
	endproperty
	a_spot_nocool: assert property (p_spot_nocool) else $error("Spot not selected");
	c_cool: cover property (state_q == ST_COOL ##1 state_q == ST_HEAT);
	c_hold: cover property (state_q == ST_HOLD ##1 state_q == ST_DONE);
	c_fault: cover property (weld_fire_o ##1 !temp_ok);
endmodule // sws_seam_seq

`default_nettype wire

// ===== sws_operator_model.sv
`timescale 1ns/1ps
`default_nettype none

module sws_operator_model (
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire sws_pkg::sws_init_type req_i,
	input  wire logic                  temp_req_i,
	output var  sws_pkg::sws_init_type init_o,
	output var  logic                  temp_o,
	output var  logic                  line_sync_o,
	output var  logic                  mid_o
);
	import sws_pkg::*;

	logic [5:0] ph_q;

	// Mains cycle of 40 clocks, zero cross at phase 0
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ph_q <= 6'h00;
		end else begin
			ph_q <= (ph_q == 6'h27) ? 6'h00 : ph_q + 6'h01;
		end
	end

	// Switch contacts follow the operator, mid-cycle strobe for sampling
	always_ff @(posedge clk_i) begin
		init_o      <= req_i;
		temp_o      <= temp_req_i;
		line_sync_o <= (ph_q < 6'h14);
		mid_o       <= (ph_q == 6'h1E);
	end
endmodule // sws_operator_model

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end

module tb_top;
	import sws_pkg::*;

	logic          clk_i, resetn_i, psel, penable, pwrite, tens, units, temp_req;
	logic          line_sync, temp_ok, mid, pready, pslverr, fire, meas, regl, fault, irq;
	logic          rerr;
	logic [7:0]    paddr, err;
	logic [31:0]   pwdata, prdata, rdat;
	logic [6:0]    pct;
	logic [5:0]    station;
	logic [15:0]   fpat, mpat, rpat;
	sws_init_type  req, init;
	int            mismatches, checks_done;

	sws_operator_model op (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
		.temp_req_i(temp_req), .init_o(init), .temp_o(temp_ok),
		.line_sync_o(line_sync), .mid_o(mid));

	sws_seam_seq dut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .init_i(init),
		.line_sync_i(line_sync), .temp_switch_closed_i(temp_ok),
		.data_tens_btn_i(tens), .data_units_btn_i(units), .weld_fire_o(fire),
		.percent_o(pct), .measure_only_o(meas), .regulate_o(regl),
		.error_code_o(err), .fault_o(fault), .station_id_o(station), .irq_o(irq));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic conclude();
		$display("Mismatches %0d of %0d checks", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) @(posedge clk_i);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic sched(input logic [4:0] i, input logic [6:0] p, input logic [27:0] t);
		apb(1'b1, ADR_SCHED_SEL, {17'h0, p, 3'h0, i});
		apb(1'b1, ADR_SCHED_DAT, {4'h0, t});
	endtask

	task automatic lines(input int n);
		repeat (n) begin
			@(posedge clk_i);
			while (mid !== 1'b1) @(posedge clk_i);
			fpat = {fpat[14:0], fire};
			mpat = {mpat[14:0], meas};
			rpat = {rpat[14:0], regl};
		end
	endtask

	task automatic state_is(input sws_state_type s);
		apb(1'b0, ADR_STATUS, 32'h0);
		`CHK("state", 3'(s), rdat[10:8])
	endtask

	task automatic start(input logic [31:0] ctrl, input sws_init_type r);
		apb(1'b1, ADR_CTRL, ctrl);
		fpat = 16'h0;
		mpat = 16'h0;
		rpat = 16'h0;
		lines(1);
		req <= r;
	endtask

	task automatic go_idle();
		req <= 3'b000;
		lines(8);
		state_is(ST_IDLE);
	endtask

	task automatic press(input logic up);
		if (up) tens <= 1'b1; else units <= 1'b1;
		repeat (4) @(posedge clk_i);
		tens  <= 1'b0;
		units <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic t_regs();
		logic [7:0] a [5] = '{ADR_CTRL, ADR_STATION, ADR_STATUS, ADR_IRQ_STAT, ADR_IRQ_MASK};
		foreach (a[k]) begin
			apb(1'b0, a[k], 32'h0);
			`CHK("reset value", 32'h0, rdat)
		end
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rdat)
		`CHK("slverr", 1'b1, rerr)
		apb(1'b1, ADR_STATION, 32'h0000_002A);
		apb(1'b0, ADR_STATION, 32'h0);
		`CHK("station", 32'h2A, rdat)
		`CHK("slverr ok", 1'b0, rerr)
		`CHK("station pin", 6'h2A, station)
		sched(5'h00, 7'h1E, {7'd2, 7'd2, 7'd2, 7'd1});
		sched(SCHED_SECOND, 7'h32, {7'd1, 7'd0, 7'd1, 7'd1});
		sched(SCHED_THIRD, 7'h46, {7'd1, 7'd3, 7'd1, 7'd1});
	endtask

	task automatic t_spot();
		apb(1'b1, ADR_IRQ_MASK, 32'h1);
		start(32'h0, 3'b001);
		lines(8);
		`CHK("spot fire", 16'h0060, fpat)
		`CHK("irq done", 1'b1, irq)
		go_idle();
		apb(1'b0, ADR_IRQ_STAT, 32'h0);
		`CHK("done bit", 1'b1, rdat[IRQ_DONE])
		@(posedge clk_i);
		`CHK("irq cleared", 1'b0, irq)
	endtask

	task automatic t_open_heat();
		start(32'h1, 3'b001);
		lines(6);
		`CHK("seam fire", 16'h0019, fpat)
		req <= 3'b000;
		lines(1);
		`CHK("stop fire", 1'b0, fire)
		state_is(ST_HOLD);
		go_idle();
	endtask

	task automatic t_open_cool();
		start(32'h1, 3'b001);
		lines(4);
		`CHK("heat len", 16'h0006, fpat)
		req <= 3'b000;
		lines(1);
		state_is(ST_COOL);
		lines(1);
		state_is(ST_HOLD);
		go_idle();
	endtask

	task automatic t_select();
		start(32'h1, 3'b001);
		lines(2);
		`CHK("pct dialed", 7'h1E, pct)
		req <= 3'b011;
		repeat (3) @(posedge clk_i);
		apb(1'b0, ADR_STATUS, 32'h0);
		`CHK("sched second", SCHED_SECOND, rdat[20:16])
		`CHK("pct second", 7'h32, pct)
		lines(5);
		`CHK("continuous", 5'h1F, fpat[4:0])
		req <= 3'b111;
		repeat (3) @(posedge clk_i);
		apb(1'b0, ADR_STATUS, 32'h0);
		`CHK("sched third", SCHED_THIRD, rdat[20:16])
		`CHK("pct third", 7'h46, pct)
		apb(1'b0, ADR_IRQ_STAT, 32'h0);
		`CHK("sched event", 1'b1, rdat[IRQ_SCHED])
		go_idle();
	endtask

	task automatic t_adjust();
		start({24'h0, SEAM_ADJUST}, 3'b001);
		lines(2);
		press(1'b1);
		`CHK("pct up", 7'h1F, pct)
		press(1'b0);
		press(1'b0);
		`CHK("pct down", 7'h1D, pct)
		go_idle();
	endtask

	task automatic t_combo();
		start({24'h0, SEAM_COMBO}, 3'b001);
		lines(4);
		req <= 3'b011;
		fpat = 16'h0;
		lines(8);
		`CHK("spot once", 32'd1, $countones(fpat))
		apb(1'b0, ADR_STATUS, 32'h0);
		`CHK("spot sched", SCHED_SECOND, rdat[20:16])
		go_idle();
		start({15'h0, 1'b1, 8'h0, SEAM_COMBO}, 3'b001);
		lines(1);
		state_is(ST_PRE);
		`CHK("pre no fire", 1'b0, fire)
		go_idle();
	endtask

	task automatic t_delay();
		start(32'h24, 3'b010);
		lines(5);
		`CHK("fire", 16'h000F, fpat)
		`CHK("measure", 16'h000C, mpat)
		`CHK("regulate", 16'h0003, rpat)
		go_idle();
	endtask

	task automatic t_temp();
		apb(1'b0, ADR_IRQ_STAT, 32'h0);
		apb(1'b1, ADR_IRQ_MASK, 32'h2);
		start(32'h1, 3'b010);
		lines(3);
		temp_req <= 1'b0;
		repeat (6) @(posedge clk_i);
		`CHK("fire cut", 1'b0, fire)
		`CHK("error", ERR_OVERTEMP, err)
		`CHK("fault", 1'b1, fault)
		`CHK("irq fault", 1'b1, irq)
		temp_req <= 1'b1;
		req      <= 3'b000;
		lines(2);
		`CHK("error clear", ERR_NONE, err)
		apb(1'b0, ADR_IRQ_STAT, 32'h0);
		`CHK("fault bit", 1'b1, rdat[IRQ_FAULT])
		@(posedge clk_i);
		`CHK("irq clear", 1'b0, irq)
		go_idle();
	endtask

	initial begin
		repeat (80000) @(posedge clk_i);
		mismatches++;
		conclude();
	end

	initial begin
		{resetn_i, psel, penable, pwrite, tens, units} = 6'h00;
		{paddr, pwdata, req, temp_req} = {8'h00, 32'h0, 3'b000, 1'b1};
		mismatches  = 0;
		checks_done = 0;
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		t_regs();
		t_spot();
		t_open_heat();
		t_open_cool();
		t_select();
		t_adjust();
		t_combo();
		t_delay();
		t_temp();
		conclude();
	end
endmodule // tb_top

`default_nettype wire
